//--- hdl/ams_scheduler.sv
// Measurement scheduler: registers, autonomous timing, decimation, buffer and interrupts.
// Assumes a converter that answers each start pulse with one convDone pulse, and an
// external buffer memory that takes bufPush entries and reports reads on bufPop.
`timescale 1ns/10ps
module ams_scheduler #(
  parameter int MS_CYCLES = ams_pkg::MS_CYCLES,
  parameter int BUF_DEPTH = ams_pkg::BUF_DEPTH
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  input  wire logic               cmdValid,
  input  wire ams_pkg::ams_cmd_t  cmd,
  output logic                    cmdAck,
  output logic                    cmdNak,
  output logic [15:0]             rdData,
  output ams_pkg::ams_conv_t      convReq,
  input  wire logic               convDone,
  input  wire logic [21:0]        convData,
  output logic [23:0]             tempResult,
  output logic [23:0]             presResult,
  output logic                    bufPush,
  output ams_pkg::ams_entry_t     bufEntry,
  output logic                    bufOverwrite,
  input  wire logic               bufPop,
  output logic [1:0]              bufPolicy,
  output logic [5:0]              fillCount,
  input  wire logic               thrEvent,
  input  wire logic               thrLevel,
  input  wire logic               intClear,
  output logic [2:0]              intPending,
  output logic                    intPin,
  output logic                    biasOn,
  output logic                    autoActive
);
  import ams_pkg::*;

  localparam int MSW = $clog2(MS_CYCLES + 1);

  if (MS_CYCLES < 1 || BUF_DEPTH < 1 || BUF_DEPTH > 63) begin : g_check
    $error("ams_scheduler: MS_CYCLES or BUF_DEPTH out of range");
  end

  typedef struct packed {
    ams_state_t  st;
    logic        autoOn;
    logic        single;
    logic        issued;
    logic        presDue;
    logic [5:0]  tCnt;
    logic [5:0]  pCnt;
    logic [MSW-1:0] msCnt;
    logic [15:0] msElapsed;
    logic [15:0] presCfg;
    logic [15:0] tempCfg;
    logic [15:0] opSet;
    logic [5:0]  fill;
    logic        pushPend;
    logic        setDone;
    logic [2:0]  pend;
    logic        intPin;
    logic        thrPulse;
    logic        bias;
    logic        ack;
    logic        nak;
    logic [15:0] rdData;
    ams_conv_t   conv;
    logic        push;
    logic        overwrite;
    ams_entry_t  entry;
  } ams_sched_t;

  ams_sched_t s_q;
  ams_sched_t s_d;

  logic        tempSample;
  logic        presSample;
  logic [23:0] tempFilt;
  logic [23:0] presFilt;

  //////////////////////////////////////////////////////////////////////////////
  // Field access helpers

  function automatic logic [6:0] ratioOf(input logic [15:0] cfg);
    logic [2:0] code;
    code = cfg[RATIO_LSB +: 3];
    if (code > RATIO_MAX_CODE) begin
      code = RATIO_MAX_CODE;
    end
    ratioOf = 7'h01 << code;
  endfunction

  function automatic logic [3:0] osrOf(input logic [15:0] cfg);
    logic [3:0] code;
    code = cfg[OSR_LSB +: 4];
    if (code > OSR_LAST_CODE) begin
      osrOf = OSR_MAX_STEP;
    end else if (code == 4'h0) begin
      osrOf = 4'h1;
    end else begin
      osrOf = code;
    end
  endfunction

  function automatic logic [15:0] regRead(input logic [7:0] addr, input ams_sched_t s);
    case (addr)
      PRES_CFG_ADDR: regRead = s.presCfg;
      TEMP_CFG_ADDR: regRead = s.tempCfg;
      OPSET_ADDR:    regRead = s.opSet;
      default:       regRead = 16'h0000;
    endcase
  endfunction

  function automatic logic knownAddr(input logic [7:0] addr);
    knownAddr = (addr == PRES_CFG_ADDR) || (addr == TEMP_CFG_ADDR) || (addr == OPSET_ADDR);
  endfunction

  function automatic logic cfgAddr(input logic [7:0] addr);
    cfgAddr = (addr == PRES_CFG_ADDR) || (addr == TEMP_CFG_ADDR);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  logic        busy;
  logic        cycleStart;
  logic        tDue;
  logic        pDue;
  logic        finish;
  logic        popOk;
  logic [5:0]  fillA;
  logic [4:0]  thr;
  logic [1:0]  policy;
  logic [3:0]  delayCode;
  logic [2:0]  cause;
  logic        msTick;

  always_comb begin
    s_d        = s_q;
    busy       = (s_q.st != ST_IDLE);
    cycleStart = 1'b0;
    tDue       = 1'b0;
    pDue       = 1'b0;
    finish     = 1'b0;
    popOk      = 1'b0;
    fillA      = s_q.fill;
    thr        = s_q.opSet[THR_LSB +: 5];
    policy     = s_q.opSet[POLICY_LSB +: 2];
    delayCode  = s_q.opSet[DELAY_LSB +: 4];
    cause      = 3'h0;
    msTick     = 1'b0;

    s_d.ack        = 1'b0;
    s_d.nak        = 1'b0;
    s_d.conv.start = 1'b0;
    s_d.push       = 1'b0;
    s_d.overwrite  = 1'b0;
    s_d.setDone    = 1'b0;
    s_d.pushPend   = 1'b0;

    // Host commands
    if (cmdValid) begin
      s_d.nak = 1'b1;
      case (cmd.op)
        OP_READ_REG, OP_READ_CFG: begin
          if (knownAddr(cmd.addr) && (cmd.op == OP_READ_REG || cfgAddr(cmd.addr))) begin
            s_d.nak    = 1'b0;
            s_d.ack    = 1'b1;
            s_d.rdData = regRead(cmd.addr, s_q);
          end
        end
        OP_READ_OPSET: begin
          s_d.nak    = 1'b0;
          s_d.ack    = 1'b1;
          s_d.rdData = s_q.opSet;
        end
        OP_WRITE_REG, OP_WRITE_CFG, OP_WRITE_OPSET: begin
          if (!s_q.autoOn) begin
            if (cmd.op == OP_WRITE_OPSET || (cmd.op == OP_WRITE_REG && cmd.addr == OPSET_ADDR))
            begin
              s_d.nak   = 1'b0;
              s_d.ack   = 1'b1;
              s_d.opSet = cmd.data & 16'he7ff;
            end else if (cfgAddr(cmd.addr) && !busy) begin
              s_d.nak = 1'b0;
              s_d.ack = 1'b1;
              if (cmd.addr == PRES_CFG_ADDR) begin
                s_d.presCfg = cmd.data & 16'h03ff;
              end else begin
                s_d.tempCfg = cmd.data & 16'h03ff;
              end
            end
          end
        end
        OP_CONVERT: begin
          if (!s_q.autoOn && !busy) begin
            s_d.nak    = 1'b0;
            s_d.ack    = 1'b1;
            s_d.single = 1'b1;
            cycleStart = 1'b1;
          end
        end
        OP_START_AUTO: begin
          if (!s_q.autoOn && !busy && delayCode != 4'h0) begin
            s_d.nak    = 1'b0;
            s_d.ack    = 1'b1;
            s_d.autoOn = 1'b1;
            s_d.tCnt   = 6'h00;
            s_d.pCnt   = 6'h00;
            cycleStart = 1'b1;
          end
        end
        OP_STOP_AUTO: begin
          s_d.nak    = 1'b0;
          s_d.ack    = 1'b1;
          s_d.autoOn = 1'b0;
          s_d.tCnt   = 6'h00;
          s_d.pCnt   = 6'h00;
        end
        OP_NVM_READ, OP_NVM_WRITE: begin
          if (!s_q.autoOn && knownAddr(cmd.addr)) begin
            s_d.nak = 1'b0;
            s_d.ack = 1'b1;
            s_d.rdData = regRead(cmd.addr, s_q);
          end
        end
        default: s_d.nak = 1'b1;
      endcase
    end

    // Delay timer, counted from the end of the previous set
    if (s_q.st == ST_DELAY) begin
      if (s_q.msCnt == MSW'(MS_CYCLES - 1)) begin
        s_d.msCnt = '0;
        msTick    = 1'b1;
      end else begin
        s_d.msCnt = s_q.msCnt + 1'b1;
      end
      if (msTick && s_q.msElapsed != 16'hffff) begin
        s_d.msElapsed = s_q.msElapsed + 16'h0001;
      end
      if (!s_d.autoOn) begin
        s_d.st = ST_IDLE;
      end else if (s_q.msElapsed >= DELAY_MS[delayCode]) begin
        cycleStart = 1'b1;
      end
    end

    // Start of a measurement cycle, decimation decides who is due
    if (cycleStart) begin
      if (s_d.single) begin
        tDue = 1'b1;
        pDue = 1'b1;
      end else begin
        tDue = ({1'b0, s_d.tCnt} + 7'h01 == ratioOf(s_q.tempCfg));
        pDue = ({1'b0, s_d.pCnt} + 7'h01 == ratioOf(s_q.presCfg));
        s_d.tCnt = tDue ? 6'h00 : s_d.tCnt + 6'h01;
        s_d.pCnt = pDue ? 6'h00 : s_d.pCnt + 6'h01;
      end
      s_d.presDue = pDue;
      s_d.issued  = 1'b0;
      s_d.msCnt     = '0;
      s_d.msElapsed = 16'h0000;
      if (tDue) begin
        s_d.st = ST_TEMP;
      end else if (pDue) begin
        s_d.st = ST_PRES;
      end else begin
        s_d.st = ST_DELAY;
      end
    end

    // Conversions, temperature before pressure
    if (s_q.st == ST_TEMP || s_q.st == ST_PRES) begin
      if (!s_q.issued) begin
        s_d.issued        = 1'b1;
        s_d.conv.start    = 1'b1;
        s_d.conv.pressure = (s_q.st == ST_PRES);
        s_d.conv.osrStep  = osrOf(s_q.st == ST_PRES ? s_q.presCfg : s_q.tempCfg);
      end else if (convDone) begin
        s_d.issued = 1'b0;
        if (s_q.st == ST_TEMP && s_q.presDue) begin
          s_d.st = ST_PRES;
        end else begin
          finish       = 1'b1;
          s_d.pushPend = (s_q.st == ST_PRES);
        end
      end
    end

    if (finish) begin
      s_d.setDone   = 1'b1;
      s_d.msCnt     = '0;
      s_d.msElapsed = 16'h0000;
      if (s_q.single || !s_d.autoOn) begin
        s_d.single = 1'b0;
        s_d.st     = ST_IDLE;
      end else begin
        s_d.st = ST_DELAY;
      end
    end

    // Buffer fill tracking and policy
    if (policy == 2'b00) begin
      s_d.fill = 6'h00;
    end else begin
      popOk = bufPop && (s_q.fill != 6'h00);
      fillA = s_q.fill - {5'h00, popOk};
      if (s_q.pushPend) begin
        s_d.entry.temp = tempFilt;
        s_d.entry.pres = presFilt;
        if (fillA < 6'(BUF_DEPTH)) begin
          s_d.push = 1'b1;
          fillA    = fillA + 6'h01;
        end else if (policy[1]) begin
          s_d.push      = 1'b1;
          s_d.overwrite = 1'b1;
        end
      end
      s_d.fill = fillA;
    end

    // Interrupt causes: set done, buffer level, threshold event
    cause[0] = s_q.setDone;
    cause[1] = (thr != 5'h00) && (s_d.fill == {1'b0, thr}) && (s_q.fill != {1'b0, thr});
    cause[2] = thrEvent;
    if (s_q.opSet[INTMODE_BIT] && cause != 3'h0) begin
      s_d.pend = cause;
    end else begin
      s_d.pend = (intClear ? 3'h0 : s_q.pend) | cause;
    end
    s_d.thrPulse = thrEvent;
    s_d.intPin   = (s_q.pend[1:0] != 2'b00) ||
                   (s_q.opSet[INTCONT_BIT] ? thrLevel : s_q.thrPulse);
    s_d.bias     = s_q.opSet[FASTSTRT_BIT] || (s_d.st == ST_TEMP) || (s_d.st == ST_PRES);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_q         <= '0;
      s_q.st      <= ST_IDLE;
      s_q.presCfg <= CHAN_CFG_RST;
      s_q.tempCfg <= CHAN_CFG_RST;
      s_q.opSet   <= OPSET_RST;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result paths

  assign tempSample = convDone && s_q.issued && (s_q.st == ST_TEMP);
  assign presSample = convDone && s_q.issued && (s_q.st == ST_PRES);

  ams_iir_chan u_temp_chan (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .sampleValid (tempSample),
    .sample      (convData),
    .smoothing   (s_q.tempCfg[FILT_LSB +: 3]),
    .result      (tempFilt)
  );

  ams_iir_chan u_pres_chan (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .sampleValid (presSample),
    .sample      (convData),
    .smoothing   (s_q.presCfg[FILT_LSB +: 3]),
    .result      (presFilt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign cmdAck       = s_q.ack;
  assign cmdNak       = s_q.nak;
  assign rdData       = s_q.rdData;
  assign convReq      = s_q.conv;
  assign tempResult   = tempFilt;
  assign presResult   = presFilt;
  assign bufPush      = s_q.push;
  assign bufEntry     = s_q.entry;
  assign bufOverwrite = s_q.overwrite;
  assign bufPolicy    = s_q.opSet[POLICY_LSB +: 2];
  assign fillCount    = s_q.fill;
  assign intPending   = s_q.pend;
  assign intPin       = s_q.intPin;
  assign biasOn       = s_q.bias;
  assign autoActive   = s_q.autoOn;

endmodule // ams_scheduler

//--- pkg/ams_pkg.sv
// Constants, field layouts and carriers of the measurement scheduler.
// Assumes one 20 MHz clock and a command decoder that hands in parsed host commands.
package ams_pkg;

  localparam int CLK_HZ    = 20_000_000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int BUF_DEPTH = 32;

  localparam logic [7:0]  PRES_CFG_ADDR = 8'h61;
  localparam logic [7:0]  TEMP_CFG_ADDR = 8'h62;
  localparam logic [7:0]  OPSET_ADDR    = 8'h64;
  localparam logic [15:0] CHAN_CFG_RST  = 16'h0004;
  localparam logic [15:0] OPSET_RST     = 16'h0000;

  // Channel configuration fields
  localparam int OSR_LSB   = 0;
  localparam int FILT_LSB  = 4;
  localparam int RATIO_LSB = 7;
  // Operating register fields
  localparam int DELAY_LSB    = 0;
  localparam int POLICY_LSB   = 4;
  localparam int THR_LSB      = 6;
  localparam int INTCONT_BIT  = 13;
  localparam int FASTSTRT_BIT = 14;
  localparam int INTMODE_BIT  = 15;

  localparam logic [3:0] OSR_MAX_STEP = 4'h9;
  localparam logic [3:0] OSR_LAST_CODE = 4'h8;
  localparam logic [2:0] RATIO_MAX_CODE = 3'h6;

  // Autonomous delay per code in milliseconds, code 0 is off
  localparam logic [15:0] DELAY_MS [16] = '{16'h0000, 16'h0000, 16'h0001, 16'h0005,
                                            16'h000a, 16'h0014, 16'h0032, 16'h0064,
                                            16'h00c8, 16'h01f4, 16'h03e8, 16'h07d0,
                                            16'h1388, 16'h2710, 16'h4e20, 16'hea60};

  typedef enum logic [3:0] {
    OP_READ_REG   = 4'h0,
    OP_WRITE_REG  = 4'h1,
    OP_READ_CFG   = 4'h2,
    OP_WRITE_CFG  = 4'h3,
    OP_READ_OPSET  = 4'h4,
    OP_WRITE_OPSET = 4'h5,
    OP_CONVERT    = 4'h6,
    OP_START_AUTO = 4'h7,
    OP_STOP_AUTO  = 4'h8,
    OP_NVM_READ   = 4'h9,
    OP_NVM_WRITE  = 4'ha
  } ams_op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_TEMP  = 2'b01,
    ST_PRES  = 2'b11,
    ST_DELAY = 2'b10
  } ams_state_t;

  typedef struct packed {
    ams_op_t     op;
    logic [7:0]  addr;
    logic [15:0] data;
  } ams_cmd_t;

  typedef struct packed {
    logic       start;
    logic       pressure;
    logic [3:0] osrStep;
  } ams_conv_t;

  typedef struct packed {
    logic [23:0] temp;
    logic [23:0] pres;
  } ams_entry_t;

endpackage

//--- hdl/ams_iir_chan.sv
// Per-channel result path with the optional IIR smoothing filter.
// Assumes sampleValid is a one-cycle pulse carrying a 22-bit compensated result.
`timescale 1ns/10ps
module ams_iir_chan (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        sampleValid,
  input  wire logic [21:0] sample,
  input  wire logic [2:0]  smoothing,
  output logic      [23:0] result
);
  import ams_pkg::*;

  typedef struct packed {
    logic [23:0] raw;
    logic [23:0] mean;
    logic        fresh;
    logic        enPrev;
    logic [23:0] result;
  } ams_iir_t;

  ams_iir_t s_q;
  ams_iir_t s_d;
  logic        filtOn;
  logic [23:0] padded;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d    = s_q;
    filtOn = (smoothing != 3'h0);
    padded = {sample, 2'b00};
    s_d.enPrev = filtOn;
    if (filtOn && !s_q.enPrev) begin
      if (s_q.fresh) begin
        s_d.mean = s_q.raw;
      end
      s_d.fresh = 1'b0;
    end
    if (sampleValid) begin
      s_d.raw = padded;
      if (filtOn) begin
        s_d.mean = s_d.mean - (s_d.mean >> smoothing) + (padded >> smoothing);
      end else begin
        s_d.fresh = 1'b1;
      end
    end
    s_d.result = filtOn ? s_d.mean : s_d.raw;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign result = s_q.result;

endmodule // ams_iir_chan

//--- sim/ams_conv_model.sv
// Converter model: answers each start pulse with one done pulse and a fixed result.
// Assumes convReq is registered on the rising edge of ref_clk.
`timescale 1ns/10ps
module ams_conv_model #(
  parameter logic [21:0] T_VAL = 22'h012345,
  parameter logic [21:0] P_VAL = 22'h2abcde
) (
  input  wire logic               ref_clk,
  input  wire ams_pkg::ams_conv_t convReq,
  output logic                    convDone,
  output logic [21:0]             convData,
  output int                      nTemp,
  output int                      nPres,
  output logic [3:0]              lastOsr,
  output logic                    orderBad
);
  int   cnt = 0;
  logic isPres = 1'b0;
  logic sinceTemp = 1'b0;
  initial begin
    convDone = 1'b0;
    convData = 22'h0;
    nTemp = 0;
    nPres = 0;
    lastOsr = 4'h0;
    orderBad = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Temperature answers quickly, pressure slowly; data toggles outside done
  always @(negedge ref_clk) begin
    convDone <= (cnt == 1);
    convData <= (cnt == 1) ? (isPres ? P_VAL : T_VAL) : ~convData;
    if (cnt != 0) cnt <= cnt - 1;
    if (convReq.start) begin
      isPres <= convReq.pressure;
      lastOsr <= convReq.osrStep;
      cnt <= convReq.pressure ? 6 : 2;
      if (convReq.pressure) begin
        nPres <= nPres + 1;
        sinceTemp <= 1'b0;
        if (!sinceTemp) orderBad <= 1'b1;
      end else begin
        nTemp <= nTemp + 1;
        sinceTemp <= 1'b1;
      end
    end
  end
endmodule // ams_conv_model

//--- sim/ams_scheduler_monitor.sv
// Checker of the scheduler ports, bound into every ams_scheduler instance.
// Assumes the ports and package of ams_scheduler.
`timescale 1ns/10ps
module ams_scheduler_monitor #(
  parameter int BUF_DEPTH = 32
) (
  input wire logic              ref_clk,
  input wire logic              rst_b,
  input wire logic              cmdValid,
  input wire ams_pkg::ams_cmd_t cmd,
  input wire logic              cmdAck,
  input wire logic              cmdNak,
  input wire logic [15:0]       rdData,
  input wire logic [23:0]       tempResult,
  input wire logic [23:0]       presResult,
  input wire logic              bufPush,
  input wire ams_pkg::ams_entry_t bufEntry,
  input wire logic              bufOverwrite,
  input wire logic [1:0]        bufPolicy,
  input wire logic [5:0]        fillCount,
  input wire logic              autoActive
);
  import ams_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  a_answer_once: assert property (cmdValid |=> cmdAck ^ cmdNak)
    else $error("command not answered once");
  a_idle_quiet: assert property (!cmdValid |=> !cmdAck && !cmdNak)
    else $error("answer without command");
  a_auto_write_nak: assert property (cmdValid && autoActive && cmd.op inside
    {OP_WRITE_REG, OP_WRITE_CFG, OP_WRITE_OPSET, OP_CONVERT} |=> cmdNak)
    else $error("write or convert accepted in autonomous mode");
  a_auto_nvm_nak: assert property (cmdValid && autoActive &&
    (cmd.op == OP_NVM_READ || cmd.op == OP_NVM_WRITE) |=> cmdNak)
    else $error("memory action accepted in autonomous mode");
  a_push_pair: assert property (bufPush |->
    bufEntry.temp == tempResult && bufEntry.pres == presResult)
    else $error("buffer entry not the latest pair");
  a_push_policy: assert property (bufPush |-> bufPolicy != 2'h0)
    else $error("push with buffer off");
  a_fill_max: assert property (fillCount <= 6'(BUF_DEPTH))
    else $error("fill count above depth");
  a_overwrite_mode: assert property (bufOverwrite |-> bufPush && bufPolicy[1])
    else $error("overwrite outside overwrite policy");
  a_rd_stable: assert property (!cmdAck |-> $stable(rdData))
    else $error("read data moved without answer");
  a_auto_by_cmd: assert property ($rose(autoActive) |-> cmdAck || $past(cmdAck))
    else $error("autonomous mode without start");
endmodule // ams_scheduler_monitor

bind ams_scheduler ams_scheduler_monitor #(.BUF_DEPTH(BUF_DEPTH)) mon (.ref_clk, .rst_b,
  .cmdValid, .cmd, .cmdAck, .cmdNak, .rdData, .tempResult, .presResult, .bufPush,
  .bufEntry, .bufOverwrite, .bufPolicy, .fillCount, .autoActive);

//--- sim/auto_measurement_scheduler_test.sv
// Testbench: host command sequences against the scheduler and a converter model.
// Assumes the design package; 20 MHz clock, inputs driven on falling edges.
`timescale 1ns/10ps
module auto_measurement_scheduler_test;
  import ams_pkg::*;
  localparam logic [21:0] TV = 22'h012345;
  localparam logic [21:0] PV = 22'h2abcde;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cmdValid = 1'b0;
  ams_cmd_t    cmd = '0;
  logic        intClear = 1'b0;
  logic        thrEvent = 1'b0;
  logic        thrLevel = 1'b0;
  logic        cmdAck, cmdNak, convDone, bufPush, bufOverwrite, intPin, biasOn, autoActive;
  logic [15:0] rdData;
  ams_conv_t   convReq;
  logic [21:0] convData;
  logic [23:0] tempResult, presResult;
  ams_entry_t  bufEntry;
  logic [1:0]  bufPolicy;
  logic [5:0]  fillCount;
  logic [2:0]  intPending;
  logic [3:0]  lastOsr;
  logic        orderBad;
  int          nTemp, nPres, t0, p0, tb0, pb0;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          nPush = 0;
  int          cycles = 0;
  always #25 ref_clk = ~ref_clk;
  ams_scheduler #(.MS_CYCLES(4), .BUF_DEPTH(32)) uut (.ref_clk, .rst_b, .cmdValid, .cmd,
    .cmdAck, .cmdNak, .rdData, .convReq, .convDone, .convData, .tempResult, .presResult,
    .bufPush, .bufEntry, .bufOverwrite, .bufPop(1'b0), .bufPolicy, .fillCount,
    .thrEvent, .thrLevel, .intClear, .intPending, .intPin, .biasOn, .autoActive);
  ams_conv_model #(.T_VAL(TV), .P_VAL(PV)) conv (.ref_clk, .convReq, .convDone, .convData,
    .nTemp, .nPres, .lastOsr, .orderBad);
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (rst_b && bufPush === 1'b1) nPush <= nPush + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic doCmd(input ams_op_t op, input logic [7:0] a, input logic [15:0] d,
                       input logic ack);
    @(negedge ref_clk);
    cmdValid = 1'b1;
    cmd = '{op, a, d};
    @(negedge ref_clk);
    cmdValid = 1'b0;
    chk("cmdAck", ack, cmdAck);
    chk("cmdNak", !ack, cmdNak);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    doCmd(OP_READ_REG, 8'h61, 16'h0, 1'b1);
    chk("pres cfg", 24'h0004, rdData);
    doCmd(OP_READ_CFG, 8'h62, 16'h0, 1'b1);
    chk("temp cfg", 24'h0004, rdData);
    doCmd(OP_READ_REG, 8'h70, 16'h0, 1'b0);
    doCmd(OP_WRITE_OPSET, 8'h64, 16'h4092, 1'b1);
    chk("bufPolicy", 24'h1, bufPolicy);
    @(negedge ref_clk);
    chk("biasOn", 24'h1, biasOn);
    $display("test registers done");
    doCmd(OP_CONVERT, 8'h00, 16'h0, 1'b1);
    for (int i = 0; i < 100 && bufPush !== 1'b1; i++) @(negedge ref_clk);
    chk("tempResult", {TV, 2'b00}, tempResult);
    chk("presResult", {PV, 2'b00}, presResult);
    chk("bufEntry", {PV, 2'b00}, bufEntry.pres);
    chk("osrStep", 24'h4, lastOsr);
    $display("test convert done");
    doCmd(OP_WRITE_CFG, 8'h61, 16'h0084, 1'b1);
    doCmd(OP_READ_REG, 8'h61, 16'h0, 1'b1);
    chk("pres cfg", 24'h0084, rdData);
    tb0 = nTemp;
    pb0 = nPres;
    doCmd(OP_START_AUTO, 8'h00, 16'h0, 1'b1);
    chk("autoActive", 24'h1, autoActive);
    repeat (150) @(negedge ref_clk);
    doCmd(OP_WRITE_CFG, 8'h62, 16'h0005, 1'b0);
    doCmd(OP_WRITE_REG, 8'h62, 16'h0005, 1'b0);
    doCmd(OP_CONVERT, 8'h00, 16'h0, 1'b0);
    doCmd(OP_NVM_READ, 8'h61, 16'h0, 1'b0);
    doCmd(OP_READ_REG, 8'h62, 16'h0, 1'b1);
    chk("temp cfg", 24'h0004, rdData);
    repeat (150) @(negedge ref_clk);
    doCmd(OP_STOP_AUTO, 8'h00, 16'h0, 1'b1);
    for (int i = 0; i < 200 && autoActive !== 1'b0; i++) @(negedge ref_clk);
    repeat (30) @(negedge ref_clk);
    t0 = nTemp - tb0;
    p0 = nPres - pb0;
    repeat (60) @(negedge ref_clk);
    chk("no new starts", t0 + p0, nTemp - tb0 + nPres - pb0);
    chk("ratio", 24'h1, (p0 > 2) && (t0 == 2 * p0 || t0 == 2 * p0 + 1));
    chk("order", 24'h0, orderBad);
    chk("fillCount", nPush, fillCount);
    chk("alert", 24'h1, intPending[1]);
    $display("test autonomous done");
    @(negedge ref_clk);
    intClear = 1'b1;
    @(negedge ref_clk);
    intClear = 1'b0;
    chk("intPending", 24'h0, intPending);
    doCmd(OP_WRITE_OPSET, 8'h64, 16'h0000, 1'b1);
    @(negedge ref_clk);
    chk("fill cleared", 24'h0, fillCount);
    chk("biasOn", 24'h0, biasOn);
    $display("test clear done");
    doCmd(OP_WRITE_OPSET, 8'h64, 16'h2000, 1'b1);
    thrLevel = 1'b1;
    @(negedge ref_clk);
    chk("intPin level", 24'h1, intPin);
    thrLevel = 1'b0;
    @(negedge ref_clk);
    chk("intPin low", 24'h0, intPin);
    doCmd(OP_WRITE_OPSET, 8'h64, 16'h8000, 1'b1);
    thrEvent = 1'b1;
    @(negedge ref_clk);
    thrEvent = 1'b0;
    chk("intPending", 24'h4, intPending);
    @(negedge ref_clk);
    chk("intPin pulse", 24'h1, intPin);
    @(negedge ref_clk);
    chk("intPin end", 24'h0, intPin);
    $display("test interrupt pin done");
    doCmd(OP_WRITE_CFG, 8'h62, 16'h0014, 1'b1);
    doCmd(OP_CONVERT, 8'h00, 16'h0, 1'b1);
    repeat (20) @(negedge ref_clk);
    chk("filtered temp", {TV, 2'b00}, tempResult);
    chk("intPending", 24'h1, intPending);
    $display("test filter done");
    finish_test();
  end
endmodule // auto_measurement_scheduler_test
